// >>> verilog/pfmm_pkg.sv
// Constants and carrier types for the protected PDH multiframe mapper
package pfmm_pkg;
  // Multiframe geometry
  localparam int TS_PER_FRAME      = 32;
  localparam int FR_PER_BLOCK      = 8;
  localparam int BL_PER_SB         = 8;
  localparam int SB_PER_MF         = 3;
  localparam int FRAMES_PER_MF     = 192;
  localparam int SLOTS_PER_MF      = 6144;
  localparam int SB_BYTES          = 2048;
  localparam int BLOCK_BYTES       = 256;
  // Line timing, paced by the network's own 2048 kHz clock
  localparam int MULTIFRAME_DURATION_US = 24000;
  localparam int FRAME_PERIOD_US        = 125;
  localparam int LINE_RATE_KBPS         = 2048;
  // Slot positions
  localparam logic [4:0] TS_LINE_SYNC = 5'h00;
  localparam logic [4:0] TS_LINE_SUPV = 5'h10;
  localparam logic [4:0] TS_MF_MGMT   = 5'h01;
  localparam logic [4:0] TS_MF_SUPV   = 5'h02;
  localparam logic [4:0] TS_LAST      = 5'h1F;
  localparam logic [2:0] IDX_LAST     = 3'h7;
  localparam logic [1:0] SB_LAST      = 2'h2;
  // Capacity split per block: 238 usable bytes after reserved slots
  localparam int USABLE_PER_MF     = 5760;
  localparam int MGMT_PER_MF       = 48;
  localparam logic [7:0] TPB_HIGH  = 8'hE9;  // 233 transport bytes
  localparam logic [7:0] TPB_PROT  = 8'hE0;  // 224 transport bytes
  localparam logic [7:0] FEC_HIGH  = 8'h05;
  localparam logic [7:0] FEC_PROT  = 8'h0E;
  localparam int FEC_MAX           = 14;
  // Transport frame sizes per variant
  localparam int TRANSPORT_FRAME_LENGTH_HIGH = 5596;
  localparam int TRANSPORT_FRAME_LENGTH_PROT = 5380;
  localparam logic [12:0] TF_BYTES_HIGH = 13'h15D8;  // 5592
  localparam logic [12:0] TF_BYTES_PROT = 13'h1500;  // 5376
  localparam logic [12:0] SLOTS_MF_W    = 13'h1800;  // 6144
  // Fill and reset values, and the GF(256) field polynomial
  localparam logic [7:0] PAD_BYTE   = 8'h55;
  localparam logic [7:0] IDLE_BYTE  = 8'hFF;
  localparam logic [7:0] GF_POLY    = 8'h1D;

  typedef struct packed {
    logic [1:0] sb;
    logic [2:0] bl;
    logic [2:0] fr;
    logic [4:0] ts;
  } pfmm_pos_t;

  typedef struct packed {
    logic [7:0] line_sync_byte;
    logic [7:0] line_supervision_byte;
  } pfmm_net_t;

  typedef struct packed {
    logic [23:0] timestamp;
    logic        crc_violation;
    logic [7:0]  err_field;
    logic [7:0]  line_err_field;
    logic        err_override;
  } pfmm_mgmt_t;
endpackage

// >>> verilog/pfmm_fec_gen.sv
// Reed-Solomon check symbol generator over GF(256), one symbol per root
`timescale 1ns/100ps
module pfmm_fec_gen #(
  parameter int NSYM = 14
) (
  input  wire logic       clock_in,
  input  wire logic       rst_n_in,
  input  wire logic       clear_in,
  input  wire logic       data_valid_in,
  input  wire logic [7:0] data_in,
  input  wire logic [3:0] sel_in,
  output logic      [7:0] sym_out
);
  import pfmm_pkg::*;

  function automatic logic [7:0] mul_alpha_pow(input logic [7:0] v, input int k);
    logic [7:0] r;
    r = v;
    for (int i = 0; i < k; i++) begin
      r = {r[6:0], 1'b0} ^ (r[7] ? GF_POLY : 8'h00);
    end
    return r;
  endfunction

  logic [7:0] acc_r [NSYM];

  // Horner evaluation of the block polynomial at alpha^(i+1)
  for (genvar i = 0; i < NSYM; i++) begin : g_sym
    always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        acc_r[i] <= 8'h00;
      end else if (clear_in) begin
        acc_r[i] <= 8'h00;
      end else if (data_valid_in) begin
        acc_r[i] <= mul_alpha_pow(acc_r[i], i + 1) ^ data_in;
      end
    end
  end

  always_comb begin
    sym_out = 8'h00;
    if (32'(sel_in) < NSYM) begin
      sym_out = acc_r[sel_in];
    end
  end
endmodule // pfmm_fec_gen

// >>> verilog/pfmm_mapper.sv
// Transport-frame to 2048 kbit/s protected multiframe mapper, transmit side
// How it works
// - 24 ms multiframe of 192 frames
// - 3 superblocks of 8 blocks each
// - Block is 8 frames of 32 bytes
// - Frame is 32 byte-wide timeslots
// - Timeslot 0 carries only line sync byte
// - Timeslot 16 carries only line supervision byte
// - High variant: 5592 transport, 120 FEC bytes
// - Protected variant: 5376 transport, 336 FEC bytes
// - High variant frame length 5596 bytes
// - Protected variant frame length 5380 bytes
// - Leading sync field never sent; from index -4
// - Line-side error status may replace carried status
// - Reed-Solomon check symbols protect block data
// - Timestamp bits spread across management bytes
// - Management byte in ts1 of frame 0
// - Supervision byte in ts2 of frame 0
// - Management byte holds block, superblock numbers
`timescale 1ns/100ps
module pfmm_mapper (
  input  wire logic                  clock_in,
  input  wire logic                  rst_n_in,
  input  wire logic                  link_clk_in,
  input  wire logic                  variant_in,
  input  wire pfmm_pkg::pfmm_net_t   net_in,
  input  wire pfmm_pkg::pfmm_mgmt_t  mgmt_in,
  input  wire logic [7:0]            supv_byte_in,
  input  wire logic [7:0]            tf_data_in,
  input  wire logic                  tf_valid_in,
  output logic                       tf_ready_out,
  output logic                       line_data_out,
  output logic                       mf_start_out,
  output logic                       underrun_out
);
  import pfmm_pkg::*;

  logic [2:0]  lk_sync_r;
  logic        bit_en;
  logic [2:0]  bit_cnt_r;
  logic        load;
  pfmm_pos_t   pos_r;
  logic        pos_zero;
  logic [7:0]  shift_r;
  logic        variant_r;
  logic [23:0] stamp_r;
  logic        crc_r;
  logic [7:0]  err_r;
  logic [7:0]  didx_r;
  logic [7:0]  hold_r;
  logic        hold_valid_r;
  logic        hold_valid_nxt;
  logic [12:0] acc_cnt_r;
  logic [12:0] acc_cnt_nxt;
  logic        accept;
  logic        consume;
  logic        is_data;
  logic        is_fec;
  logic [7:0]  tpb;
  logic [12:0] tf_limit;
  logic [7:0]  byte_nxt;
  logic [7:0]  fec_sym;
  logic [4:0]  mf_blk;
  logic        stamp_bit;
  logic        sig_bit;

  // Line clock is foreign: two flops before the edge detector
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lk_sync_r <= 3'h0;
    end else begin
      lk_sync_r <= {lk_sync_r[1:0], link_clk_in};
    end
  end
  assign bit_en = lk_sync_r[1] & ~lk_sync_r[2];
  assign load   = bit_en && (bit_cnt_r == IDX_LAST);

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bit_cnt_r <= IDX_LAST;
    end else if (bit_en) begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
    end
  end

  // Slot position walks ts, frame, block, superblock
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pos_r <= '0;
    end else if (load) begin
      pos_r.ts <= pos_r.ts + 5'h01;
      if (pos_r.ts == TS_LAST) begin
        pos_r.fr <= pos_r.fr + 3'h1;
        if (pos_r.fr == IDX_LAST) begin
          pos_r.bl <= pos_r.bl + 3'h1;
          if (pos_r.bl == IDX_LAST) begin
            pos_r.sb <= (pos_r.sb == SB_LAST) ? 2'h0 : pos_r.sb + 2'h1;
          end
        end
      end
    end
  end
  assign pos_zero = (pos_r == '0);

  // Per-multiframe settings are frozen so a frame never mixes variants
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      variant_r <= 1'b0;
      stamp_r   <= 24'h000000;
      crc_r     <= 1'b0;
      err_r     <= 8'h00;
    end else if (load && pos_zero) begin
      variant_r <= variant_in;
      stamp_r   <= mgmt_in.timestamp;
      crc_r     <= mgmt_in.crc_violation;
      err_r     <= mgmt_in.err_override ? mgmt_in.line_err_field
                                        : mgmt_in.err_field;
    end
  end

  assign tpb      = variant_r ? TPB_PROT : TPB_HIGH;
  assign tf_limit = variant_r ? TF_BYTES_PROT : TF_BYTES_HIGH;
  assign is_data  = (pos_r.ts != TS_LINE_SYNC) && (pos_r.ts != TS_LINE_SUPV) &&
                    !((pos_r.fr == 3'h0) && (pos_r.ts <= TS_MF_SUPV));
  assign consume  = load && is_data && (didx_r < tpb);
  assign is_fec   = is_data && (didx_r >= tpb);
  assign mf_blk   = {pos_r.sb, pos_r.bl};

  // Index within the block's data area, restarted after the supervision byte
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      didx_r <= 8'h00;
    end else if (load) begin
      if (pos_r.fr == 3'h0 && pos_r.ts == TS_MF_SUPV) begin
        didx_r <= 8'h00;
      end else if (is_data) begin
        didx_r <= didx_r + 8'h01;
      end
    end
  end

  pfmm_fec_gen #(
    .NSYM (FEC_MAX)
  ) u_fec (
    .clock_in      (clock_in),
    .rst_n_in      (rst_n_in),
    .clear_in      (load && pos_r.fr == 3'h0 && pos_r.ts == TS_LINE_SYNC),
    .data_valid_in (consume),
    .data_in       (hold_valid_r ? hold_r : PAD_BYTE),
    .sel_in        (4'(didx_r - tpb)),
    .sym_out       (fec_sym)
  );

  // Block 0 of superblock 0 carries the MSb of each 24-bit word
  always_comb begin
    stamp_bit = stamp_r[5'd23 - mf_blk];
    sig_bit   = 1'b0;
    if (pos_r.sb == 2'h0 && pos_r.bl == 3'h0) begin
      sig_bit = crc_r;
    end else if (pos_r.sb == 2'h0 && pos_r.bl == 3'h1) begin
      sig_bit = variant_r;
    end else if (pos_r.sb == 2'h1) begin
      sig_bit = err_r[3'h7 - pos_r.bl];
    end
  end

  // Byte for the slot about to go out; b0 is the MSb, sent first
  always_comb begin
    byte_nxt = IDLE_BYTE;
    if (pos_r.ts == TS_LINE_SYNC) begin
      byte_nxt = net_in.line_sync_byte;
    end else if (pos_r.ts == TS_LINE_SUPV) begin
      byte_nxt = net_in.line_supervision_byte;
    end else if (pos_r.fr == 3'h0 && pos_r.ts == TS_MF_MGMT) begin
      byte_nxt = {pos_r.bl, pos_r.sb, stamp_bit, sig_bit, 1'b0};
    end else if (pos_r.fr == 3'h0 && pos_r.ts == TS_MF_SUPV) begin
      byte_nxt = supv_byte_in;
    end else if (is_fec) begin
      byte_nxt = fec_sym;
    end else begin
      byte_nxt = hold_valid_r ? hold_r : PAD_BYTE;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      shift_r <= IDLE_BYTE;
    end else if (load) begin
      shift_r <= byte_nxt;
    end else if (bit_en) begin
      shift_r <= {shift_r[6:0], 1'b1};
    end
  end
  assign line_data_out = shift_r[7];

  // One-byte holding stage; source stops once the frame's quota is in
  assign accept         = tf_valid_in && tf_ready_out;
  assign hold_valid_nxt = accept || (hold_valid_r && !consume);
  assign acc_cnt_nxt    = (load && pos_zero) ? {12'h000, accept}
                                             : acc_cnt_r + {12'h000, accept};
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hold_r       <= PAD_BYTE;
      hold_valid_r <= 1'b0;
      acc_cnt_r    <= 13'h0000;
      tf_ready_out <= 1'b0;
    end else begin
      if (accept) begin
        hold_r <= tf_data_in;
      end
      hold_valid_r <= hold_valid_nxt;
      acc_cnt_r    <= acc_cnt_nxt;
      tf_ready_out <= !hold_valid_nxt && (acc_cnt_nxt < tf_limit);
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mf_start_out <= 1'b0;
      underrun_out <= 1'b0;
    end else begin
      mf_start_out <= load && pos_zero;
      underrun_out <= consume && !hold_valid_r;
    end
  end

  // Checking helpers
  logic [12:0] chk_slots_r;
  logic [12:0] chk_tx_r;
  logic [7:0]  chk_fec_r;
  logic        chk_seen_r;
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      chk_slots_r <= 13'h0000;
      chk_tx_r    <= 13'h0000;
      chk_fec_r   <= 8'h00;
      chk_seen_r  <= 1'b0;
    end else if (load) begin
      chk_slots_r <= pos_zero ? 13'h0001 : chk_slots_r + 13'h0001;
      chk_tx_r    <= pos_zero ? 13'h0000 : chk_tx_r + {12'h000, consume};
      chk_fec_r   <= (pos_r.fr == 3'h0 && pos_r.ts == TS_LINE_SYNC) ? 8'h00
                     : chk_fec_r + {7'h00, is_fec};
      chk_seen_r  <= chk_seen_r | pos_zero;
    end
  end

  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  mf_slot_count_a: assert property (load && pos_zero && chk_seen_r
    |-> chk_slots_r == SLOTS_MF_W)
    else $error("multiframe slot count wrong");
  sb_range_a: assert property (pos_r.sb <= SB_LAST)
    else $error("superblock out of range");
  sync_slot_a: assert property (load && pos_r.ts == TS_LINE_SYNC
    |=> shift_r == $past(net_in.line_sync_byte))
    else $error("timeslot 0 not line sync byte");
  supv_slot_a: assert property (load && pos_r.ts == TS_LINE_SUPV
    |=> shift_r == $past(net_in.line_supervision_byte))
    else $error("timeslot 16 not supervision byte");
  reserved_no_data_a: assert property (consume
    |-> pos_r.ts != TS_LINE_SYNC && pos_r.ts != TS_LINE_SUPV
        && !(pos_r.fr == 3'h0 && pos_r.ts <= TS_MF_SUPV))
    else $error("transport byte in reserved slot");
  tx_count_a: assert property (load && pos_zero && chk_seen_r
    |-> chk_tx_r == (variant_r ? TF_BYTES_PROT : TF_BYTES_HIGH))
    else $error("transport bytes per multiframe wrong");
  fec_count_a: assert property (load && pos_r.fr == 3'h0 && pos_r.ts == TS_LINE_SYNC
    && chk_seen_r |-> chk_fec_r == (variant_r ? FEC_PROT : FEC_HIGH))
    else $error("check bytes per block wrong");
  mgmt_byte_a: assert property (load && pos_r.fr == 3'h0 && pos_r.ts == TS_MF_MGMT
    |=> shift_r[7:3] == {$past(pos_r.bl), $past(pos_r.sb)})
    else $error("management counters wrong");
  ready_quota_a: assert property (tf_ready_out |-> !hold_valid_r && acc_cnt_r < tf_limit)
    else $error("ready with full stage or quota");
  bit_shift_a: assert property (bit_en && !load |=> shift_r[7] == $past(shift_r[6]))
    else $error("bit order broken");

  mf_start_c:   cover property (mf_start_out);
  underrun_c:   cover property (underrun_out);
  fec_load_c:   cover property (load && is_fec && variant_r);
  accept_mf_c:  cover property (accept ##[1:20] (load && pos_zero));
endmodule // pfmm_mapper

// >>> sim/pfmm_line_model.sv
// Network line partner: free-running line clock and byte capture of the serial line
`timescale 1ns/100ps
module pfmm_line_model #(
  parameter int DEPTH = 300
) (
  input  wire logic   clock_in,
  input  wire logic   mf_start_in,
  input  wire logic   line_bit_in,
  output logic        link_clk_out,
  output logic [15:0] rx_count_out
);
  logic [7:0] rx_mem [0:DEPTH-1];
  logic [7:0] shift_r;
  logic [2:0] bit_r;
  logic       link_d_r;

  // Network timing runs free; odd offset keeps its edges apart from clock_in
  initial begin
    link_clk_out = 1'h0;
    #37.3;
    forever #80 link_clk_out = ~link_clk_out;
  end

  // Sample mid-bit on the falling line edge, well after the mapper updates
  always @(posedge clock_in) begin
    link_d_r <= link_clk_out;
    if (mf_start_in === 1'h1) begin
      bit_r        <= 3'h0;
      rx_count_out <= 16'h0000;
    end else if (link_d_r && !link_clk_out) begin
      shift_r <= {shift_r[6:0], line_bit_in};
      bit_r   <= bit_r + 3'h1;
      if (bit_r == 3'h7 && rx_count_out < 16'(DEPTH)) begin
        rx_mem[rx_count_out] <= {shift_r[6:0], line_bit_in};
        rx_count_out         <= rx_count_out + 16'h0001;
      end
    end
  end
endmodule // pfmm_line_model

// >>> sim/tb_top.sv
// Self-checking bench for the protected multiframe mapper
`timescale 1ns/100ps
`define CHECK(got, exp) \
  begin checked++; if ((got) !== (exp)) begin errors++; \
  $display("MISMATCH %0t got %h exp %h", $time, (got), (exp)); end end
module tb_top;
  import pfmm_pkg::*;
  logic        clock_in;
  logic        rst_n_in;
  logic        link_clk;
  logic        variant;
  pfmm_net_t   net;
  pfmm_mgmt_t  mgmt;
  logic [7:0]  supv_byte;
  logic [7:0]  tf_data;
  logic        tf_valid;
  logic        tf_ready;
  logic        line_bit;
  logic        mf_start;
  logic        underrun;
  logic [15:0] rx_count;
  logic        src_on;
  int          src_n;
  int          errors;
  int          checked;
  int          mfs;
  int          unds;

  pfmm_mapper dut (
    .clock_in      (clock_in),
    .rst_n_in      (rst_n_in),
    .link_clk_in   (link_clk),
    .variant_in    (variant),
    .net_in        (net),
    .mgmt_in       (mgmt),
    .supv_byte_in  (supv_byte),
    .tf_data_in    (tf_data),
    .tf_valid_in   (tf_valid),
    .tf_ready_out  (tf_ready),
    .line_data_out (line_bit),
    .mf_start_out  (mf_start),
    .underrun_out  (underrun)
  );

  pfmm_line_model far_end (
    .clock_in     (clock_in),
    .mf_start_in  (mf_start),
    .line_bit_in  (line_bit),
    .link_clk_out (link_clk),
    .rx_count_out (rx_count)
  );

  initial begin
    clock_in = 1'h0;
    forever #2.5 clock_in = ~clock_in;
  end

  function automatic logic [7:0] stream_byte(input int n);
    return 8'(n * 37 + 11);
  endfunction

  function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    p = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) p ^= a;
      a = {a[6:0], 1'h0} ^ (a[7] ? GF_POLY : 8'h00);
    end
    return p;
  endfunction

  function automatic logic [7:0] mgmt_exp(input int bl, input logic v, input pfmm_mgmt_t m);
    logic sig;
    sig = (bl == 0) ? m.crc_violation : ((bl == 1) ? v : 1'h0);
    return {3'(bl), 2'h0, m.timestamp[23 - bl], sig, 1'h0};
  endfunction

  // Source holds each byte until taken; the mapper's ready paces it
  assign tf_data = stream_byte(src_n);
  always @(posedge clock_in) begin
    if (src_on) begin
      if (tf_valid && tf_ready) src_n <= src_n + 1;
      tf_valid <= 1'h1;
    end else begin
      src_n    <= 0;
      tf_valid <= 1'h0;
    end
  end

  always @(posedge clock_in) begin
    if (mf_start === 1'h1) mfs++;
    if (underrun === 1'h1) unds++;
  end

  task automatic final_report();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic wait_bytes(input int nb);
    int i;
    for (i = 0; i < 90000; i++) begin
      if (mfs > 0 && rx_count >= 16'(nb)) break;
      @(posedge clock_in);
    end
    if (i == 90000) begin
      errors++;
      $display("MISMATCH %0t line capture timed out", $time);
      final_report();
    end
  endtask

  task automatic apply_reset();
    @(posedge clock_in);
    rst_n_in <= 1'h0;
    src_on   <= 1'h0;
    repeat (20) @(posedge clock_in);
    `CHECK({tf_ready, line_bit, mf_start, underrun}, 4'h4)
    mfs  = 0;
    unds = 0;
    rst_n_in <= 1'h1;
    repeat (2) @(posedge clock_in);
    #1;
    `CHECK(tf_ready, 1'h1)
  endtask

  // Rebuilds every captured slot from the layout; pads lead the stream by skip
  task automatic check_line(input int nb, input logic v, input int skip, input pfmm_mgmt_t m);
    int d;
    int n;
    int fr;
    int ts;
    int tpb;
    logic [7:0] got;
    logic [7:0] e;
    logic [7:0] pw;
    logic [7:0] acc [0:13];
    tpb = v ? int'(TPB_PROT) : int'(TPB_HIGH);
    n = 0;
    d = 0;
    for (int s = 0; s < nb; s++) begin
      fr  = (s / 32) % 8;
      ts  = s % 32;
      got = far_end.rx_mem[s];
      if (ts == 0 && fr == 0) begin
        d = 0;
        for (int k = 0; k < 14; k++) acc[k] = 8'h00;
      end
      if (ts == 0) `CHECK(got, net.line_sync_byte)
      else if (ts == 16) `CHECK(got, net.line_supervision_byte)
      else if (fr == 0 && ts == 1) `CHECK(got, mgmt_exp(s / 256, v, m))
      else if (fr == 0 && ts == 2) `CHECK(got, supv_byte)
      else begin
        if (d < tpb) begin
          e = (n < skip) ? PAD_BYTE : stream_byte(n - skip);
          `CHECK(got, e)
          pw = 8'h01;
          for (int k = 0; k < 14; k++) begin
            pw     = gmul(pw, 8'h02);
            acc[k] = gmul(acc[k], pw) ^ e;
          end
          n++;
        end else `CHECK(got, acc[d - tpb])
        d++;
      end
    end
  endtask

  // Full first block and the head of the second: 233 transport plus 5 check bytes
  task automatic run_high();
    variant <= 1'h0;
    mgmt    <= '{timestamp: 24'hA5C3F0, crc_violation: 1'h1, err_field: 8'h6A,
                 line_err_field: 8'h3B, err_override: 1'h1};
    apply_reset();
    src_on <= 1'h1;
    wait_bytes(262);
    check_line(262, 1'h0, 0, mgmt);
    `CHECK(unds, 0)
    `CHECK(mfs, 1)
  endtask

  // Reset in mid-run, then a late source: first transport slot must be padded
  task automatic run_prot();
    int i;
    variant <= 1'h1;
    mgmt    <= '{timestamp: 24'h5A0F0F, crc_violation: 1'h0, err_field: 8'h81,
                 line_err_field: 8'h24, err_override: 1'h0};
    apply_reset();
    for (i = 0; i < 5000 && unds == 0; i++) @(posedge clock_in);
    `CHECK(unds, 1)
    if (unds == 0) begin
      errors++;
      $display("MISMATCH %0t underrun wait timed out", $time);
      final_report();
    end
    src_on <= 1'h1;
    wait_bytes(40);
    check_line(40, 1'h1, 1, mgmt);
    `CHECK(unds, 1)
  endtask

  initial begin
    rst_n_in  = 1'h0;
    variant   = 1'h0;
    net       = '{line_sync_byte: 8'h9B, line_supervision_byte: 8'hDF};
    mgmt      = '0;
    supv_byte = 8'hC6;
    src_on    = 1'h0;
    tf_valid  = 1'h0;
    errors    = 0;
    checked   = 0;
    mfs       = 0;
    unds      = 0;
    run_high();
    run_prot();
    final_report();
  end
endmodule // tb_top
